// ---- rtl/dmc_pkg.sv ----
// Purpose: Constants for the direct mapped code cache
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   Offsets are full 32-bit byte addresses
package dmc_pkg;
  localparam int unsigned ENTRIES      = 256;
  localparam int unsigned IDX_W        = 8;
  localparam int unsigned TAG_W        = 15;
  localparam logic [31:0] CTRL_ADDR    = 32'hffff8740;
  localparam logic [31:0] TAG_BASE     = 32'hfffff000;
  localparam logic [31:0] DATA_BASE    = 32'hfffff400;
  localparam logic [21:0] WIN_MASK_HI  = 22'h3ffffc;
  localparam int unsigned IDX_LSB      = 2;
  localparam int unsigned TAG_LSB      = 10;
  localparam int unsigned VALID_BIT    = 25;
  localparam int unsigned TAGF_LSB     = 10;
  localparam int unsigned CTRL_W       = 5;
  localparam logic [4:0]  CTRL_RESET   = 5'h00;
  localparam int unsigned DRAM_BIT     = 4;
  localparam logic [7:0]  EXT_HI       = 8'h00;
  localparam logic [7:0]  DRAM_HI      = 8'h01;
  localparam logic [31:0] UNDEF_READ   = 32'h00000000;
  // Space codes on the fetch side: 0..3 chip select, 4 DRAM, 7 other
  localparam logic [2:0]  SP_DRAM      = 3'h4;
  localparam logic [2:0]  SP_OTHER     = 3'h7;
endpackage

// ---- rtl/dmc_cache.sv ----
// Purpose: Direct mapped 1-kbyte code cache with fill control
// Assumes: Core fetch port on sys_clk, external bus controller does fills
// Notes:   Arrays double as on-chip RAM while no space is cached
// Operation
// - 1 kbyte data, 256 tag entries
// - Fifteen-bit tag compared per lookup
// - Direct mapped, 4-byte line, fill replaces
// - Only code and PC-relative external reads cached
// - Valid flag zero never hits
// - Bit 4 enables DRAM space caching
// - Bits 3..0 enable chip-select spaces
// - Control clears on reset, kept in standby
// - Bits 15..5 read undefined, write zero
// - Tag array window at fffff000
// - Data array window at fffff400
// - Tag read indexed by address bits 9..2
// - Tag write stores tag and valid
// - Data array read and write whole line
// - Array access ignored while caching enabled
// - One idle cycle before non-consecutive fill
// - Chip-select fill stretches final assertion
// - DRAM fill stretches row strobe
// - Row-down mode delays next cycle
// - First hit after miss treated as miss
// - Arrays usable as RAM when uncached
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module dmc_cache (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  input  wire logic [2:0]  fetch_space,
  input  wire logic        fetch_code,
  output logic             fetch_ack,
  output logic [31:0]      fetch_data,
  output logic             fetch_hit,
  output logic             fill_req,
  output logic [31:0]      fill_addr,
  output logic             fill_stretch,
  output logic             fill_next_delay,
  input  wire logic        fill_done,
  input  wire logic [31:0] fill_data,
  input  wire logic        ras_down_mode
);
  typedef enum logic [1:0] {
    DMC_IDLE = 2'b00,
    DMC_GAP  = 2'b01,
    DMC_FILL = 2'b11,
    DMC_ACK  = 2'b10
  } dmc_state_t;

  logic [dmc_pkg::TAG_W-1:0] tag_mem  [dmc_pkg::ENTRIES];
  logic                      vld_mem  [dmc_pkg::ENTRIES];
  logic [31:0]               data_mem [dmc_pkg::ENTRIES];

  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[dmc_pkg::IDX_LSB +: dmc_pkg::IDX_W];
  endfunction

  function automatic logic [14:0] tag_of(input logic [31:0] a);
    tag_of = a[dmc_pkg::TAG_LSB +: dmc_pkg::TAG_W];
  endfunction

  logic [4:0]  ctrl_ff;
  logic [4:0]  nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        wait_ff;
  logic        nxt_wait;
  dmc_state_t  st_ff;
  dmc_state_t  nxt_st;
  logic        last_miss_ff;
  logic        nxt_last_miss;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] fdata_ff;
  logic [31:0] nxt_fdata;
  logic        hit_ff;
  logic        nxt_hit;
  logic        freq_ff;
  logic        nxt_freq;
  logic [31:0] faddr_ff;
  logic [31:0] nxt_faddr;
  logic        stretch_ff;
  logic        nxt_stretch;
  logic        delay_ff;
  logic        nxt_delay;

  logic        any_on;
  logic        space_on;
  logic        eligible;
  logic        lookup_hit;
  logic        wr_go;
  logic        in_tag;
  logic        in_data;
  logic        in_ctrl;
  logic        tag_we;
  logic        data_we;
  logic        fill_we;
  logic [7:0]  bus_idx;
  logic [7:0]  fidx;

  assign any_on  = |ctrl_ff;
  assign bus_idx = idx_of(avs_address);
  assign fidx    = idx_of(fetch_addr);
  assign in_tag  = (avs_address[31:10] == dmc_pkg::TAG_BASE[31:10]);
  assign in_data = (avs_address[31:10] == dmc_pkg::DATA_BASE[31:10]);
  assign in_ctrl = (avs_address[31:2] == dmc_pkg::CTRL_ADDR[31:2]);
  // Writes land at the edge where the master sees waitrequest low
  assign wr_go   = avs_write & ~wait_ff;

  always_comb begin
    space_on = 1'b0;
    if (fetch_space == dmc_pkg::SP_DRAM) begin
      space_on = ctrl_ff[dmc_pkg::DRAM_BIT];
    end else if (fetch_space < dmc_pkg::SP_DRAM) begin
      space_on = ctrl_ff[fetch_space[1:0]];
    end
  end

  assign eligible   = fetch_code & space_on & (fetch_space != dmc_pkg::SP_OTHER);
  assign lookup_hit = eligible & vld_mem[fidx]
                      & (tag_mem[fidx] == tag_of(fetch_addr));

  assign tag_we  = wr_go & in_tag & ~any_on;
  assign data_we = wr_go & in_data & ~any_on;
  assign fill_we = (st_ff == DMC_FILL) & fill_done & eligible;

  // Register bus: one wait cycle, answer on the second edge
  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = rdata_ff;
    nxt_wait  = 1'b1;
    if (wr_go & in_ctrl & avs_byteenable[0]) begin
      nxt_ctrl = avs_writedata[dmc_pkg::CTRL_W-1:0];
    end
    if ((avs_read | avs_write) & wait_ff) begin
      nxt_wait  = 1'b0;
      nxt_rdata = 32'h00000000;
      if (in_ctrl) begin
        nxt_rdata = {27'h0000000, ctrl_ff};
      end else if (in_tag) begin
        if (any_on) begin
          nxt_rdata = dmc_pkg::UNDEF_READ;
        end else begin
          nxt_rdata[dmc_pkg::VALID_BIT] = vld_mem[bus_idx];
          nxt_rdata[dmc_pkg::TAGF_LSB +: dmc_pkg::TAG_W] = tag_mem[bus_idx];
        end
      end else if (in_data) begin
        nxt_rdata = any_on ? dmc_pkg::UNDEF_READ : data_mem[bus_idx];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff  <= dmc_pkg::CTRL_RESET;
      rdata_ff <= 32'h00000000;
      wait_ff  <= 1'b1;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      wait_ff  <= nxt_wait;
    end
  end

  // Arrays: forced writes and fills share the write ports
  always_ff @(posedge sys_clk) begin
    if (tag_we) begin
      tag_mem[bus_idx] <= avs_writedata[dmc_pkg::TAGF_LSB +: dmc_pkg::TAG_W];
      vld_mem[bus_idx] <= avs_writedata[dmc_pkg::VALID_BIT];
    end else if (fill_we) begin
      tag_mem[fidx] <= tag_of(fetch_addr);
      vld_mem[fidx] <= 1'b1;
    end
    if (data_we) begin
      data_mem[bus_idx] <= avs_writedata;
    end else if (fill_we) begin
      data_mem[fidx] <= fill_data;
    end
  end

  // Fetch side: lookup, idle gap, fill, answer
  always_comb begin
    nxt_st        = st_ff;
    nxt_last_miss = last_miss_ff;
    nxt_ack       = 1'b0;
    nxt_fdata     = fdata_ff;
    nxt_hit       = 1'b0;
    nxt_freq      = freq_ff;
    nxt_faddr     = faddr_ff;
    nxt_stretch   = stretch_ff;
    nxt_delay     = 1'b0;
    unique case (st_ff)
      DMC_IDLE: begin
        if (fetch_req & ~ack_ff) begin
          if (lookup_hit & ~last_miss_ff) begin
            nxt_ack       = 1'b1;
            nxt_hit       = 1'b1;
            nxt_fdata     = data_mem[fidx];
            nxt_last_miss = 1'b0;
          end else begin
            nxt_faddr     = {fetch_addr[31:2], 2'b00};
            // A hit served as a fill clears the chain, so the next hit is a hit
            nxt_last_miss = eligible & ~lookup_hit;
            if (last_miss_ff) begin
              nxt_st      = DMC_FILL;
              nxt_freq    = 1'b1;
              nxt_stretch = eligible;
            end else begin
              nxt_st = DMC_GAP;
            end
          end
        end
      end
      DMC_GAP: begin
        nxt_st      = DMC_FILL;
        nxt_freq    = 1'b1;
        nxt_stretch = eligible;
      end
      DMC_FILL: begin
        if (fill_done) begin
          nxt_freq      = 1'b0;
          nxt_stretch   = 1'b0;
          nxt_fdata     = fill_data;
          nxt_ack       = 1'b1;
          nxt_delay     = eligible & ras_down_mode &
                          (fetch_space == dmc_pkg::SP_DRAM);
          nxt_st        = DMC_ACK;
        end
      end
      DMC_ACK: begin
        nxt_st = DMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff        <= DMC_IDLE;
      last_miss_ff <= 1'b0;
      ack_ff       <= 1'b0;
      fdata_ff     <= 32'h00000000;
      hit_ff       <= 1'b0;
      freq_ff      <= 1'b0;
      faddr_ff     <= 32'h00000000;
      stretch_ff   <= 1'b0;
      delay_ff     <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      last_miss_ff <= nxt_last_miss;
      ack_ff       <= nxt_ack;
      fdata_ff     <= nxt_fdata;
      hit_ff       <= nxt_hit;
      freq_ff      <= nxt_freq;
      faddr_ff     <= nxt_faddr;
      stretch_ff   <= nxt_stretch;
      delay_ff     <= nxt_delay;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign fetch_ack       = ack_ff;
  assign fetch_data      = fdata_ff;
  assign fetch_hit       = hit_ff;
  assign fill_req        = freq_ff;
  assign fill_addr       = faddr_ff;
  assign fill_stretch    = stretch_ff;
  assign fill_next_delay = delay_ff;
endmodule
`default_nettype wire

// ---- verification/dmc_props.sv ----
// Purpose: Port assertions for the code cache
// Assumes: One clock, async high reset
// Notes:   Attached by bind
`timescale 1ns/1ps
`default_nettype none
module dmc_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fetch_req,
  input wire logic [2:0]  fetch_space,
  input wire logic        fetch_code,
  input wire logic        fetch_ack,
  input wire logic        fetch_hit,
  input wire logic        fill_req,
  input wire logic [31:0] fill_addr,
  input wire logic        fill_stretch,
  input wire logic        fill_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  answer_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  ctrl_reserved_a: assert property (!avs_waitrequest && avs_read
    && avs_address == dmc_pkg::CTRL_ADDR |-> avs_readdata[31:5] == 27'h0)
    else $error("reserved control bits not zero");
  fill_ack_a: assert property (fill_req && fill_done |=> fetch_ack && !fill_req)
    else $error("fill not answered");
  ack_pulse_a: assert property (fetch_ack |=> !fetch_ack)
    else $error("ack longer than one cycle");
  hit_ack_a: assert property (fetch_hit |-> fetch_ack)
    else $error("hit without ack");
  fill_nohit_a: assert property (fetch_ack && $past(fill_req) |-> !fetch_hit)
    else $error("filled access flagged as hit");
  bypass_nohit_a: assert property (fetch_req && (!fetch_code
    || fetch_space == dmc_pkg::SP_OTHER) |-> !fetch_hit)
    else $error("uncacheable access hit");
  stretch_fill_a: assert property (fill_stretch |-> fill_req)
    else $error("stretch outside fill");
  line_align_a: assert property (fill_req |-> fill_addr[1:0] == 2'h0)
    else $error("fill address not aligned");
endmodule
bind dmc_cache dmc_props u_props (.*);
`default_nettype wire

// ---- verification/dmc_bus_model.sv ----
// Purpose: External bus controller model answering line fills
// Assumes: Fill data is a fixed function of the line address
// Notes:   Data lines toggle while no fill is answered
`timescale 1ns/1ps
`default_nettype none
module dmc_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        fill_req,
  input  wire logic [31:0] fill_addr,
  output logic             fill_done,
  output logic [31:0]      fill_data
);
  logic [3:0] cnt_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff    <= 4'h0;
      fill_done <= 1'b0;
      fill_data <= 32'h0;
    end else begin
      fill_done <= 1'b0;
      fill_data <= ~fill_data;
      cnt_ff    <= 4'h0;
      if (fill_req && !fill_done) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff >= (slow ? 4'h4 : 4'h0)) begin
          fill_done <= 1'b1;
          fill_data <= {fill_addr[15:0] ^ 16'hc3a5, fill_addr[15:0]};
          cnt_ff    <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/dmc_cache_tb.sv ----
// Purpose: Self-checking bench for the code cache
// Assumes: Bus model answers every fill
// Notes:   Fetch gaps are compared relative to each other
`timescale 1ns/1ps
`default_nettype none
module dmc_cache_tb;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, d;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest, fetch_req = 1'b0, fetch_code = 1'b0, fetch_ack, h;
  logic [31:0] fetch_addr = 32'h0, fetch_data, fill_addr, fill_data;
  logic [2:0]  fetch_space = 3'h0;
  logic        fetch_hit, fill_req, fill_stretch, fill_next_delay, fill_done;
  logic        ras_down_mode = 1'b0, slow = 1'b0;
  int          num_errors = 0, compares = 0, n0, n1, nd_cnt = 0, st_cnt = 0;
  localparam logic [31:0] A = 32'h00000104, B = 32'h00000504, C = 32'h01000208;
  always #5 sys_clk = ~sys_clk;
  dmc_cache u_dut (.*);
  dmc_bus_model u_bus (.*);
  always @(posedge sys_clk) begin
    if (fill_next_delay) nd_cnt++;
    if (fill_stretch) st_cnt++;
  end
  function automatic logic [31:0] ln(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3a5, a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(negedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    @(posedge sys_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(d, e);
  endtask
  task automatic fx(input logic [31:0] a, input logic [2:0] sp, input logic cd,
                    input logic eh, output int n);
    n = 0;
    fetch_addr <= a;
    fetch_space <= sp;
    fetch_code <= cd;
    fetch_req <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    while (fill_req !== 1'b1 && fetch_ack !== 1'b1 && n < 99) begin
      n++;
      @(negedge sys_clk);
    end
    while (fetch_ack !== 1'b1) @(negedge sys_clk);
    chk(fetch_data, ln(a));
    chk({31'h0, fetch_hit}, {31'h0, eh});
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdc(dmc_pkg::CTRL_ADDR, 32'h0);
    rdc(32'h00001000, 32'h0);
    bus(1'b1, dmc_pkg::TAG_BASE + 32'h14, 32'h03fffc00);
    rdc(dmc_pkg::TAG_BASE + 32'h14, 32'h03fffc00);
    bus(1'b1, dmc_pkg::DATA_BASE + 32'h14, 32'h5a0f3c96);
    rdc(dmc_pkg::DATA_BASE + 32'h14, 32'h5a0f3c96);
    for (int i = 0; i < 256; i++) bus(1'b1, dmc_pkg::TAG_BASE + 32'(i * 4), 32'h0);
    rdc(dmc_pkg::TAG_BASE + 32'h14, 32'h0);
    bus(1'b1, dmc_pkg::CTRL_ADDR, 32'hffffffff);
    rdc(dmc_pkg::CTRL_ADDR, 32'h0000001f);
    bus(1'b1, dmc_pkg::DATA_BASE + 32'h4, 32'h12345678);
    rdc(dmc_pkg::DATA_BASE + 32'h4, 32'h0);
    slow <= 1'b1;
    fx(A, 3'h0, 1'b1, 1'b0, n0);
    slow <= 1'b0;
    fx(A, 3'h0, 1'b1, 1'b0, n1);
    chk(32'(n0), 32'(n1 + 1));
    fx(A, 3'h0, 1'b1, 1'b1, n1);
    fx(B, 3'h0, 1'b1, 1'b0, n0);
    fx(A, 3'h0, 1'b1, 1'b0, n1);
    chk(32'(n0), 32'(n1 + 1));
    fx(A, 3'h0, 1'b1, 1'b0, n1);
    fx(A, 3'h0, 1'b1, 1'b1, n1);
    chk({31'h0, st_cnt != 0}, 32'h1);
    fx(A, 3'h0, 1'b0, 1'b0, n1);
    fx(A, dmc_pkg::SP_OTHER, 1'b1, 1'b0, n1);
    bus(1'b1, dmc_pkg::CTRL_ADDR, 32'h00000010);
    fx(A, 3'h0, 1'b1, 1'b0, n1);
    ras_down_mode <= 1'b1;
    nd_cnt = 0;
    fx(C, dmc_pkg::SP_DRAM, 1'b1, 1'b0, n1);
    fx(C, dmc_pkg::SP_DRAM, 1'b1, 1'b0, n1);
    fx(C, dmc_pkg::SP_DRAM, 1'b1, 1'b1, n1);
    chk({31'h0, nd_cnt != 0}, 32'h1);
    bus(1'b1, dmc_pkg::CTRL_ADDR, 32'h0);
    rdc(dmc_pkg::DATA_BASE + 32'h208, ln(C));
    bus(1'b1, dmc_pkg::TAG_BASE + 32'h208, 32'h01000000);
    bus(1'b1, dmc_pkg::CTRL_ADDR, 32'h00000010);
    fx(C, dmc_pkg::SP_DRAM, 1'b1, 1'b0, n1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
